// ---- core/asp_map.svh ----
/*
 * Register offsets, field positions, reset values and counts of the
 * asynchronous serial port.
 * Assumes an 8-bit register port with a 2-bit word address.
 */
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

// register offsets
`define ASP_ADDR_CTRL       2'h0
`define ASP_ADDR_DATA       2'h1
`define ASP_ADDR_CFG        2'h2
`define ASP_ADDR_RELOAD     2'h3

// control register fields
`define ASP_CTRL_MODE_HI    7
`define ASP_CTRL_MODE_LO    6
`define ASP_CTRL_FILTER     5
`define ASP_CTRL_REN        4
`define ASP_CTRL_TX9        3
`define ASP_CTRL_RX9        2
`define ASP_CTRL_TI         1
`define ASP_CTRL_RI         0

// configuration register fields
`define ASP_CFG_DOUBLER     0
`define ASP_CFG_PRESCALE    1
`define ASP_CFG_RX_BUSY     6
`define ASP_CFG_TX_BUSY     7

// reset values
`define ASP_RST_BYTE        8'h00
`define ASP_RST_LINE        11'h7ff

// baud generation counts (last value of each counter)
`define ASP_PRE_SLOW_LAST   4'hb
`define ASP_PRE_FAST_LAST   4'h3
`define ASP_FIX_SLOW_LAST   2'h3
`define ASP_FIX_FAST_LAST   2'h1
`define ASP_TMR_MAX         8'hff

// sampling and framing counts
`define ASP_PHASE_LAST      4'hf
`define ASP_MID_FIRST       4'h7
`define ASP_MID_LAST        4'h9
`define ASP_DATA_LAST       3'h7
`define ASP_FRAME10_BITS    4'ha
`define ASP_FRAME11_BITS    4'hb
`define ASP_STOP_SLOT       4'h2

`endif

// ---- core/asp_pkg.sv ----
/*
 * Types of the asynchronous serial port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package asp_pkg;

    // framing mode, in the order of the two mode select bits
    typedef enum logic [1:0] {
        ASP_MODE_SYNC,
        ASP_MODE_ASYNC10,
        ASP_MODE_ASYNC11_FIXED,
        ASP_MODE_ASYNC11_TIMER
    } asp_mode_t;

    // receiver progress through a frame
    typedef enum logic [2:0] {
        ASP_RX_IDLE,
        ASP_RX_START,
        ASP_RX_DATA,
        ASP_RX_NINTH,
        ASP_RX_STOP
    } asp_rx_state_t;

endpackage

// ---- core/asp_tick_if.sv ----
/*
 * Sample tick and bit decision signals shared inside the serial port.
 * Assumes all members are driven on the rising edge of mclk.
 */
interface asp_tick_if;
    logic sampleTick;
    logic rxActive;
    logic lineIn;
    logic bitValid;
    logic bitValue;

    modport gen  (output sampleTick);
    modport smp  (input sampleTick, rxActive, lineIn,
                  output bitValid, bitValue);
    modport core (input sampleTick, bitValid, bitValue,
                  output rxActive, lineIn);
endinterface

// ---- core/asp_baud_gen.sv ----
/*
 * Sixteen-times oversampling tick for the serial port: timer driven in
 * modes 1 and 3, fixed system clock divide in mode 2.
 * Assumes configuration inputs are register outputs on mclk.
 */
`include "asp_map.svh"

module asp_baud_gen (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // configuration
    input  asp_pkg::asp_mode_t    mode,
    input  wire logic             baudDoubler,
    input  wire logic             prescaleSel,
    input  wire logic [7:0]       reloadValue,
    // tick output
    asp_tick_if.gen               tick
);
    import asp_pkg::*;

    logic [3:0] preCnt_reg;
    logic [7:0] timer_reg;
    logic       ovfHalf_reg;
    logic [1:0] fixCnt_reg;

    // timer prescale and 8-bit auto-reload overflow
    wire [3:0] preLast  = prescaleSel ? `ASP_PRE_FAST_LAST
                                      : `ASP_PRE_SLOW_LAST;
    wire       preWrap  = (preCnt_reg == preLast);
    wire       timerOvf = preWrap && (timer_reg == `ASP_TMR_MAX);
    wire [1:0] fixLast  = baudDoubler ? `ASP_FIX_FAST_LAST
                                      : `ASP_FIX_SLOW_LAST;
    wire       fixWrap  = (fixCnt_reg == fixLast);
    wire       timerMode = (mode == ASP_MODE_ASYNC10)
                        || (mode == ASP_MODE_ASYNC11_TIMER);

    // every overflow when doubled, every second one otherwise
    wire timerTick = timerOvf && (baudDoubler || ovfHalf_reg);
    wire fixTick   = (mode == ASP_MODE_ASYNC11_FIXED) && fixWrap;
    assign tick.sampleTick = timerMode ? timerTick : fixTick;

    // next values
    wire [3:0] preCnt_next  = preWrap ? 4'h0 : preCnt_reg + 4'h1;
    wire [7:0] timer_next   = !preWrap ? timer_reg
                            : timerOvf ? reloadValue
                            : timer_reg + 8'h01;
    wire       ovfHalf_next = timerOvf ? !ovfHalf_reg : ovfHalf_reg;
    wire [1:0] fixCnt_next  = fixWrap ? 2'h0 : fixCnt_reg + 2'h1;

    // counters
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            preCnt_reg  <= 4'h0;
            timer_reg   <= `ASP_RST_BYTE;
            ovfHalf_reg <= 1'b0;
            fixCnt_reg  <= 2'h0;
        end else begin
            preCnt_reg  <= preCnt_next;
            timer_reg   <= timer_next;
            ovfHalf_reg <= ovfHalf_next;
            fixCnt_reg  <= fixCnt_next;
        end
    end
endmodule

// ---- core/asp_bit_sampler.sv ----
/*
 * Receive bit decision: three samples around the middle of each bit
 * are voted, one decision per sixteen sample ticks.
 * Assumes the phase starts at the start-bit falling edge.
 */
`include "asp_map.svh"

module asp_bit_sampler (
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  sys_rst,
    // ticks and decisions
    asp_tick_if.smp    tick
);
    import asp_pkg::*;

    logic [3:0] phase_reg;
    logic [1:0] window_reg;
    logic       bitValid_reg;
    logic       bitValue_reg;

    // two of three wins
    function automatic logic vote(input logic [2:0] s);
        vote = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
    endfunction

    wire midSample = tick.sampleTick && (phase_reg >= `ASP_MID_FIRST)
                  && (phase_reg <= `ASP_MID_LAST);
    wire decide    = tick.rxActive && tick.sampleTick
                  && (phase_reg == `ASP_MID_LAST);

    // next values
    wire [3:0] phase_next  = !tick.rxActive ? 4'h0
                           : tick.sampleTick ? phase_reg + 4'h1
                           : phase_reg;
    wire [1:0] window_next = midSample ? {window_reg[0], tick.lineIn}
                                       : window_reg;
    wire       value_next  = decide
                           ? vote({window_reg, tick.lineIn})
                           : bitValue_reg;

    assign tick.bitValid = bitValid_reg;
    assign tick.bitValue = bitValue_reg;

    // phase, window and decision
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_reg    <= 4'h0;
            window_reg   <= 2'h3;
            bitValid_reg <= 1'b0;
            bitValue_reg <= 1'b1;
        end else begin
            phase_reg    <= phase_next;
            window_reg   <= window_next;
            bitValid_reg <= decide;
            bitValue_reg <= value_next;
        end
    end
endmodule

// ---- core/asp_serial_port.sv ----
/*
 * Asynchronous full-duplex serial port, modes 1 to 3, with
 * multiprocessor address filtering and its register port.
 * Assumes the register port and the line input are synchronous to mclk;
 * mode 0 is not built and leaves both directions idle.
 */
// How it works
// - mode 1 frame: start, eight data bits LSB first, stop; ten bits.
// - mode 1 acceptance stores the stop bit in received_ninth_bit.
// - modes 1, 3: timer 1 overflow clocks divider of 32, or 16 doubled.
// - timer reload: rate = 2^doubler/32 * clk / (prescale*(256-reload)).
// - mode 1 buffer write sends start, data LSB first, stop on output.
// - with receive enabled, a falling input edge begins a frame.
// - input sampled sixteen times per bit; middle three samples voted.
// - start bit voted nonzero abandons the frame and waits again.
// - mode 1 accepts if flag clear and, filtering, stop bit is one.
// - acceptance loads byte, stores stop bit, sets receive flag.
// - modes 2, 3 frame: start, eight data, ninth bit, stop; eleven.
// - mode 2 rate is clock over 64, or over 32 when doubled.
// - mode 2 sends ninth bit before stop; transmit flag at stop bit.
// - mode 2 filtering accepts only with ninth and stop bits both one.
// - mode 3 equals mode 2 except rate comes from timer divider.
// - modes 2, 3 filtering: receive flag set only for ninth bit one.
// - mode bits: 00 sync, 01 ten-bit, 10 and 11 eleven-bit.
// - hardware never clears receive or transmit flag; software does.
`include "asp_map.svh"

module asp_serial_port (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [1:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdData,
    // serial line
    input  wire logic        lineInputPin,
    output logic             lineOutputPin
);
    import asp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers

    asp_mode_t     mode;
    logic [1:0]    modeSelect_reg;
    logic          addressFilterEnable_reg;
    logic          receiveEnable_reg;
    logic          transmitNinthBit_reg;
    logic          receivedNinthBit_reg;
    logic          transmitFlag_reg;
    logic          receiveFlag_reg;
    logic          baudDoubler_reg;
    logic          timerPrescaleSelect_reg;
    logic [7:0]    timerReloadValue_reg;
    logic [7:0]    rxBuffer_reg;
    logic [7:0]    rdData_reg;

    // transmitter
    logic [10:0]   txShift_reg;
    logic [3:0]    txCount_reg;
    logic [3:0]    txPhase_reg;

    // receiver
    asp_rx_state_t rxState_reg;
    logic [2:0]    rxBitCnt_reg;
    logic [7:0]    rxShift_reg;
    logic          rxNinth_reg;
    logic          lineInPrev_reg;

    ////////////////////////////////////////////////////////////////////
    // submodules

    asp_tick_if tick ();

    asp_baud_gen u_baud (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .mode        (mode),
        .baudDoubler (baudDoubler_reg),
        .prescaleSel (timerPrescaleSelect_reg),
        .reloadValue (timerReloadValue_reg),
        .tick        (tick.gen)
    );

    asp_bit_sampler u_sampler (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .tick    (tick.smp)
    );

    ////////////////////////////////////////////////////////////////////
    // mode decode and register access strobes

    assign mode = asp_mode_t'(modeSelect_reg);

    wire asyncMode = (mode != ASP_MODE_SYNC);
    wire frame11   = (mode == ASP_MODE_ASYNC11_FIXED)
                  || (mode == ASP_MODE_ASYNC11_TIMER);

    wire ctrlWrite   = regWrite && (regAddr == `ASP_ADDR_CTRL);
    wire dataWrite   = regWrite && (regAddr == `ASP_ADDR_DATA);
    wire cfgWrite    = regWrite && (regAddr == `ASP_ADDR_CFG);
    wire reloadWrite = regWrite && (regAddr == `ASP_ADDR_RELOAD);

    ////////////////////////////////////////////////////////////////////
    // transmitter

    // a buffer write while a frame is in flight is dropped
    wire txBusy    = (txCount_reg != 4'h0);
    wire txStart   = dataWrite && asyncMode && !txBusy;
    wire txBitEnd  = txBusy && tick.sampleTick
                  && (txPhase_reg == `ASP_PHASE_LAST);

    // ninth slot holds the stop level in ten-bit frames
    wire       txNinth = frame11 ? transmitNinthBit_reg : 1'b1;
    wire [3:0] txBits  = frame11 ? `ASP_FRAME11_BITS
                                 : `ASP_FRAME10_BITS;

    // stop bit reaches the line at this bit boundary
    wire txStopOut = txBitEnd && (txCount_reg == `ASP_STOP_SLOT);

    // frame shifts out LSB first, ones fill behind it
    wire [10:0] txShift_next =
        txStart  ? {1'b1, txNinth, regWrData, 1'b0}
      : txBitEnd ? {1'b1, txShift_reg[10:1]}
      : txShift_reg;

    wire [3:0] txCount_next = txStart  ? txBits
                            : txBitEnd ? txCount_reg - 4'h1
                            : txCount_reg;

    wire [3:0] txPhase_next = txStart ? 4'h0
                            : (txBusy && tick.sampleTick)
                            ? txPhase_reg + 4'h1
                            : txPhase_reg;

    // line output straight from the shift register
    assign lineOutputPin = txShift_reg[0];

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            txShift_reg <= `ASP_RST_LINE;
            txCount_reg <= 4'h0;
            txPhase_reg <= 4'h0;
        end else begin
            txShift_reg <= txShift_next;
            txCount_reg <= txCount_next;
            txPhase_reg <= txPhase_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receiver

    // falling edge of the line while waiting
    wire rxEdge   = lineInPrev_reg && !lineInputPin;
    wire rxAllow  = receiveEnable_reg && asyncMode;
    wire rxBusy   = (rxState_reg != ASP_RX_IDLE);
    wire bitValid = tick.bitValid;
    wire bitValue = tick.bitValue;

    assign tick.rxActive = rxBusy;
    assign tick.lineIn   = lineInputPin;

    // stop bit decision and acceptance test
    wire stopDecide = (rxState_reg == ASP_RX_STOP) && bitValid;
    wire filterPass = frame11 ? (rxNinth_reg && bitValue)
                              : bitValue;
    wire rxAccept   = stopDecide && !receiveFlag_reg
                   && (!addressFilterEnable_reg || filterPass);

    // ninth bit in eleven-bit frames, stop bit in ten-bit frames
    wire rxNinthValue = frame11 ? rxNinth_reg
                                : bitValue;

    // frame sequencing
    asp_rx_state_t rxState_next;
    always_comb begin
        rxState_next = rxState_reg;
        case (rxState_reg)
            ASP_RX_IDLE: begin
                if (rxAllow && rxEdge) begin
                    rxState_next = ASP_RX_START;
                end
            end
            ASP_RX_START: begin
                if (bitValid) begin
                    rxState_next = bitValue ? ASP_RX_IDLE
                                            : ASP_RX_DATA;
                end
            end
            ASP_RX_DATA: begin
                if (bitValid && (rxBitCnt_reg == `ASP_DATA_LAST)) begin
                    rxState_next = frame11 ? ASP_RX_NINTH
                                           : ASP_RX_STOP;
                end
            end
            ASP_RX_NINTH: begin
                if (bitValid) begin
                    rxState_next = ASP_RX_STOP;
                end
            end
            ASP_RX_STOP: begin
                if (bitValid) begin
                    rxState_next = ASP_RX_IDLE;
                end
            end
            default: begin
                rxState_next = ASP_RX_IDLE;
            end
        endcase
        // disabling reception drops a frame in progress
        if (!rxAllow) begin
            rxState_next = ASP_RX_IDLE;
        end
    end

    // data bits arrive LSB first
    wire dataBit = (rxState_reg == ASP_RX_DATA) && bitValid;
    wire [7:0] rxShift_next  = dataBit
                             ? {bitValue, rxShift_reg[7:1]}
                             : rxShift_reg;
    wire [2:0] rxBitCnt_next = (rxState_reg == ASP_RX_START) ? 3'h0
                             : dataBit ? rxBitCnt_reg + 3'h1
                             : rxBitCnt_reg;
    wire       rxNinth_next  = ((rxState_reg == ASP_RX_NINTH)
                             && bitValid) ? bitValue : rxNinth_reg;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rxState_reg    <= ASP_RX_IDLE;
            rxBitCnt_reg   <= 3'h0;
            rxShift_reg    <= `ASP_RST_BYTE;
            rxNinth_reg    <= 1'b0;
            lineInPrev_reg <= 1'b1;
        end else begin
            rxState_reg    <= rxState_next;
            rxBitCnt_reg   <= rxBitCnt_next;
            rxShift_reg    <= rxShift_next;
            rxNinth_reg    <= rxNinth_next;
            lineInPrev_reg <= lineInputPin;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control and status flags

    // hardware set wins over a software write in the same cycle
    wire receiveFlag_next  = rxAccept ? 1'b1
                           : ctrlWrite ? regWrData[`ASP_CTRL_RI]
                           : receiveFlag_reg;
    wire transmitFlag_next = txStopOut ? 1'b1
                           : ctrlWrite ? regWrData[`ASP_CTRL_TI]
                           : transmitFlag_reg;
    wire rxNinthBit_next   = rxAccept ? rxNinthValue
                           : ctrlWrite ? regWrData[`ASP_CTRL_RX9]
                           : receivedNinthBit_reg;

    // received byte kept only on acceptance
    wire [7:0] rxBuffer_next = rxAccept ? rxShift_reg
                                        : rxBuffer_reg;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            receiveFlag_reg      <= 1'b0;
            transmitFlag_reg     <= 1'b0;
            receivedNinthBit_reg <= 1'b0;
            rxBuffer_reg         <= `ASP_RST_BYTE;
        end else begin
            receiveFlag_reg      <= receiveFlag_next;
            transmitFlag_reg     <= transmitFlag_next;
            receivedNinthBit_reg <= rxNinthBit_next;
            rxBuffer_reg         <= rxBuffer_next;
        end
    end

    // plain software settings
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            modeSelect_reg          <= 2'h0;
            addressFilterEnable_reg <= 1'b0;
            receiveEnable_reg       <= 1'b0;
            transmitNinthBit_reg    <= 1'b0;
            baudDoubler_reg         <= 1'b0;
            timerPrescaleSelect_reg <= 1'b0;
            timerReloadValue_reg    <= `ASP_RST_BYTE;
        end else begin
            if (ctrlWrite) begin
                modeSelect_reg <= {regWrData[`ASP_CTRL_MODE_HI],
                                   regWrData[`ASP_CTRL_MODE_LO]};
                addressFilterEnable_reg <= regWrData[`ASP_CTRL_FILTER];
                receiveEnable_reg       <= regWrData[`ASP_CTRL_REN];
                transmitNinthBit_reg    <= regWrData[`ASP_CTRL_TX9];
            end
            if (cfgWrite) begin
                baudDoubler_reg         <= regWrData[`ASP_CFG_DOUBLER];
                timerPrescaleSelect_reg <= regWrData[`ASP_CFG_PRESCALE];
            end
            if (reloadWrite) begin
                timerReloadValue_reg <= regWrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path

    // register words as software sees them
    logic [7:0] ctrlWord;
    logic [7:0] cfgWord;
    always_comb begin
        ctrlWord = `ASP_RST_BYTE;
        ctrlWord[`ASP_CTRL_MODE_HI] = modeSelect_reg[1];
        ctrlWord[`ASP_CTRL_MODE_LO] = modeSelect_reg[0];
        ctrlWord[`ASP_CTRL_FILTER]  = addressFilterEnable_reg;
        ctrlWord[`ASP_CTRL_REN]     = receiveEnable_reg;
        ctrlWord[`ASP_CTRL_TX9]     = transmitNinthBit_reg;
        ctrlWord[`ASP_CTRL_RX9]     = receivedNinthBit_reg;
        ctrlWord[`ASP_CTRL_TI]      = transmitFlag_reg;
        ctrlWord[`ASP_CTRL_RI]      = receiveFlag_reg;
        cfgWord = `ASP_RST_BYTE;
        cfgWord[`ASP_CFG_DOUBLER]   = baudDoubler_reg;
        cfgWord[`ASP_CFG_PRESCALE]  = timerPrescaleSelect_reg;
        cfgWord[`ASP_CFG_RX_BUSY]   = rxBusy;
        cfgWord[`ASP_CFG_TX_BUSY]   = txBusy;
    end

    // address select for the read word
    wire [7:0] readSel =
        (regAddr == `ASP_ADDR_CTRL) ? ctrlWord
      : (regAddr == `ASP_ADDR_DATA) ? rxBuffer_reg
      : (regAddr == `ASP_ADDR_CFG)  ? cfgWord
      : timerReloadValue_reg;

    // read data stands only in the cycle after the strobe
    wire [7:0] rdData_next = regRead ? readSel : `ASP_RST_BYTE;
    assign regRdData = rdData_reg;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_reg <= `ASP_RST_BYTE;
        end else begin
            rdData_reg <= rdData_next;
        end
    end
endmodule

// ---- testbench/asp_serial_port_monitor.sv ----
/* checker of the serial port, bound to its ports.
   assumes one clock domain, software-only control fields. */
module asp_serial_port_monitor (
    // clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // register port
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdData,
    // serial line
    input wire logic       lineInputPin,
    input wire logic       lineOutputPin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [7:0] ctrl_reg, cfg_reg, rld_reg;
    ////////////////////////////////////////
    // shadow copies of what software last wrote
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= 8'h00;
            cfg_reg  <= 8'h00;
            rld_reg  <= 8'h00;
        end else if (regWrite) begin
            if (regAddr == 2'h0) ctrl_reg <= regWrData;
            if (regAddr == 2'h2) cfg_reg <= regWrData;
            if (regAddr == 2'h3) rld_reg <= regWrData;
        end
    end
    ////////////////////////////////////////
    // bits last at least 32 clocks at the fastest rate
    sequence s_low8; !lineOutputPin [*8]; endsequence
    sequence s_high8; lineOutputPin [*8]; endsequence
    property p_rd_idle; !$past(regRead) |-> regRdData == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rst; $past(sys_rst) |-> lineOutputPin; endproperty
    a_rst: assert property (p_rst) else $error("line low after reset");
    property p_low; $fell(lineOutputPin) |-> s_low8; endproperty
    a_low: assert property (p_low) else $error("low bit too short");
    property p_high; $rose(lineOutputPin) |-> s_high8; endproperty
    a_high: assert property (p_high) else $error("high bit too short");
    property p_ctrl;
        regRead && regAddr == 2'h0 |=> regRdData[7:3] == $past(ctrl_reg[7:3]);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control readback");
    property p_cfg;
        regRead && regAddr == 2'h2 |=> regRdData[1:0] == $past(cfg_reg[1:0]);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config readback");
    property p_rld;
        regRead && regAddr == 2'h3 |=> regRdData == $past(rld_reg);
    endproperty
    a_rld: assert property (p_rld) else $error("reload readback");
    property p_mode0;
        regWrite && regAddr == 2'h1 && ctrl_reg[7:6] == 2'b00 && lineOutputPin
            |=> s_high8;
    endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 sent");
endmodule

// ---- testbench/asp_remote_uart.sv ----
/* remote uart at the far end of the serial lines.
   assumes bit periods given in mclk cycles. */
module asp_remote_uart (
    // clock
    input wire logic mclk,
    // serial lines
    input wire logic txLine,
    output logic     rxLine
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxLine = 1'b1;
    ////////////////////////////////////////
    // one frame, bit 0 first, idle high after
    task automatic send(input logic [10:0] b, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            rxLine <= b[i];
            repeat (per) @(posedge mclk);
        end
        rxLine <= 1'b1;
    endtask
    // short low pulse that is no start bit
    task automatic glitch(input int n);
        rxLine <= 1'b0;
        repeat (n) @(posedge mclk);
        rxLine <= 1'b1;
        repeat (64) @(posedge mclk);
    endtask
    // sample a frame at bit middles after the start edge
    task automatic grab(input int n, input int per, output logic [10:0] b);
        int t;
        b = 11'h7ff;
        t = 0;
        while (txLine !== 1'b0 && t < 5000) begin
            @(posedge mclk);
            t++;
        end
        repeat (per / 2) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            b[i] = txLine;
            repeat (per) @(posedge mclk);
        end
    endtask
endmodule

// ---- testbench/asp_serial_port_tb_top.sv ----
/* directed tests of the serial port in modes 0 to 3.
   assumes the remote model and the monitor are compiled first. */
bind asp_serial_port asp_serial_port_monitor mon (.mclk(mclk),
    .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .lineInputPin(lineInputPin), .lineOutputPin(lineOutputPin));
module asp_serial_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWrData = 8'h00, regRdData, d;
    logic lineIn, lineOut;
    logic [10:0] f;
    int errors = 0, tests_run = 0;
    always #4 mclk = ~mclk;
    asp_serial_port dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .lineInputPin(lineIn),
        .lineOutputPin(lineOut));
    asp_remote_uart remote (.mclk(mclk), .txLine(lineOut), .rxLine(lineIn));
    ////////////////////////////////////////
    // register port cycles and comparison
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic chk(input string s, input logic [10:0] seen, e);
        tests_run++;
        if (seen !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", s, e, seen);
        end
    endtask
    task automatic rdChk(input logic [1:0] a, input logic [7:0] e);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        d = regRdData;
        @(posedge mclk);
        chk("register", {3'b000, d}, {3'b000, e});
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////
    // test sequence
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int a = 0; a < 4; a++) rdChk(2'(a), 8'h00);
        chk("idle line", {10'h000, lineOut}, 11'h001);
        $display("test reset done");
        // mode 2 doubled: 32-clock bits, ninth bit one
        wr(2'h2, 8'h01);
        wr(2'h0, 8'h98);
        wr(2'h1, 8'ha5);
        remote.grab(11, 32, f);
        chk("mode2 frame", f, {2'b11, 8'ha5, 1'b0});
        rdChk(2'h0, 8'h9a);
        $display("test mode2 send done");
        // filtered receive: data dropped, glitch ignored, address taken
        wr(2'h0, 8'hb0);
        remote.send({2'b10, 8'h3c, 1'b0}, 11, 32);
        rdChk(2'h0, 8'hb0);
        remote.glitch(6);
        remote.send({2'b11, 8'h5a, 1'b0}, 11, 32);
        rdChk(2'h0, 8'hb5);
        remote.send({2'b11, 8'h77, 1'b0}, 11, 32);
        rdChk(2'h1, 8'h5a);
        rdChk(2'h0, 8'hb5);
        $display("test mode2 receive done");
        // mode 1 on the timer: /4, reload 0xff, doubled: 64-clock bits
        wr(2'h3, 8'hff);
        wr(2'h2, 8'h03);
        wr(2'h0, 8'h70);
        repeat (3200) @(posedge mclk);
        rdChk(2'h3, 8'hff);
        remote.send({2'b00, 8'hc3, 1'b0}, 10, 64);
        rdChk(2'h0, 8'h70);
        remote.send({2'b01, 8'hc3, 1'b0}, 10, 64);
        rdChk(2'h0, 8'h75);
        rdChk(2'h1, 8'hc3);
        wr(2'h1, 8'h96);
        remote.grab(10, 64, f);
        chk("mode1 frame", f, {2'b11, 8'h96, 1'b0});
        $display("test mode1 done");
        // mode 3 on the timer, not doubled: 128-clock bits
        wr(2'h2, 8'h02);
        wr(2'h0, 8'hd8);
        wr(2'h1, 8'h3c);
        remote.grab(11, 128, f);
        chk("mode3 frame", f, {2'b11, 8'h3c, 1'b0});
        remote.send({2'b10, 8'he1, 1'b0}, 11, 128);
        rdChk(2'h0, 8'hdb);
        rdChk(2'h1, 8'he1);
        $display("test mode3 done");
        // mode 0 is not built: a data write leaves the line idle
        wr(2'h0, 8'h10);
        wr(2'h1, 8'h55);
        rdChk(2'h2, 8'h02);
        chk("mode0 line", {10'h000, lineOut}, 11'h001);
        $display("test mode0 done");
        summarize();
    end
    // watchdog, well beyond the expected run
    initial begin
        repeat (40000) @(posedge mclk);
        errors++;
        summarize();
    end
endmodule
